/* verilog/tftsy_pkg.sv */
// Purpose: Shared constants and types for the panel sync timing generator.
// Assumes: AHB-Lite register access with 32-bit words, one word per register.
// Notes:   The bus domain is hclk, and the panel logic runs on the dot clock.
package tftsy_pkg;
  // Byte offsets of the registers.
  localparam logic [7:0] ADDR_CTRL         = 8'h00;
  localparam logic [7:0] ADDR_AREA_SIZE    = 8'h04;
  localparam logic [7:0] ADDR_LINE_TIMING  = 8'h08;
  localparam logic [7:0] ADDR_FRAME_TIMING = 8'h0C;
  localparam logic [7:0] ADDR_PIXEL        = 8'h10;
  localparam logic [7:0] ADDR_STATUS       = 8'h14;
  // Control field positions.
  localparam int CTRL_ENABLE_BIT     = 0;
  localparam int CTRL_LINE_POL_BIT   = 1;
  localparam int CTRL_FRAME_POL_BIT  = 2;
  localparam int CTRL_CLK_INV_BIT    = 3;
  localparam int CTRL_CLK_DLY_LSB    = 4;
  localparam int CTRL_CLK_DLY_W      = 2;
  // Field width of the active width and height counts; sync and porch counts are 8 bits.
  localparam int CNT_W               = 12;
  // Reset values: polarity active high, block disabled, small panel.
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] AREA_RESET   = 32'h0010_0010;
  localparam logic [31:0] LINE_RESET   = 32'h0002_0202;
  localparam logic [31:0] FRAME_RESET  = 32'h0002_0202;
  localparam logic [31:0] PIXEL_RESET  = 32'h0000_0000;

  // Programmed timing, carried together across the clock boundary.
  typedef struct packed {
    logic [CNT_W-1:0] active_w;
    logic [CNT_W-1:0] active_h;
    logic [7:0]       line_sync_len;
    logic [7:0]       line_back_porch;
    logic [7:0]       line_front_porch;
    logic [7:0]       frame_sync_len;
    logic [7:0]       frame_back_porch;
    logic [7:0]       frame_front_porch;
    logic             line_pol_low;
    logic             frame_pol_low;
    logic [23:0]      pixel_rgb;
  } tftsy_cfg_t;

  // Phases of a line or of a frame.
  typedef enum logic [1:0] {
    PH_SYNC,
    PH_BACK,
    PH_ACTIVE,
    PH_FRONT
  } tftsy_phase_t;
endpackage : tftsy_pkg

/* verilog/tftsy_timing.sv */
// Purpose: Line and frame timing generator for an active matrix TFT panel.
// Assumes: hclk bus domain, separate dot clock input, AHB-Lite slave.
// Notes:   Configuration crosses by a toggle handshake, with status returned.
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tftsy_timing
  import tftsy_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pixel_clk,
  output logic             panel_dot_clock,
  output logic             line_sync_out,
  output logic             frame_sync_out,
  output logic             pixel_valid_out,
  output logic      [23:0] pixel_bus
);
  import tftsy_pkg::*;

  // Software registers in the bus domain.
  logic [31:0] ctrl_reg;            // Enable, polarities and dot clock setup.
  logic [31:0] area_reg;            // Active width low half, height high half.
  logic [31:0] line_reg;            // Line sync, back and front porch.
  logic [31:0] frame_reg;           // Frame sync, back and front porch.
  logic [31:0] pixel_reg;           // Colour sent during active pixels.
  // Address phase capture.
  logic        wr_pend;             // A write data phase follows.
  logic [7:0]  wr_addr;             // Offset of that write.
  logic [7:0]  rd_addr;             // Offset of a read in data phase.

  // Address phase qualifies only on NONSEQ or SEQ with hready high.
  wire         bus_go   = hsel & hready & htrans[1];
  wire  [31:0] stat_word;

  // The slave answers every transfer at once with OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Capture the address phase for the following data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= bus_go & hwrite;
      wr_addr <= haddr[7:0];
      rd_addr <= haddr[7:0];
    end
  end

  // Register writes land in the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Sync polarity defaults active high.
      // reset polarity high
      ctrl_reg  <= CTRL_RESET;
      area_reg  <= AREA_RESET;
      line_reg  <= LINE_RESET;
      frame_reg <= FRAME_RESET;
      pixel_reg <= PIXEL_RESET;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        ADDR_CTRL:         ctrl_reg  <= hwdata;
        ADDR_AREA_SIZE:    area_reg  <= hwdata;
        ADDR_LINE_TIMING:  line_reg  <= hwdata;
        ADDR_FRAME_TIMING: frame_reg <= hwdata;
        ADDR_PIXEL:        pixel_reg <= hwdata;
        default:           ctrl_reg  <= ctrl_reg;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero.
  // The mux reads registers only, so the data phase needs no wait state.
  always_comb
  begin
    case (rd_addr)
      ADDR_CTRL:         hrdata = ctrl_reg;
      ADDR_AREA_SIZE:    hrdata = area_reg;
      ADDR_LINE_TIMING:  hrdata = line_reg;
      ADDR_FRAME_TIMING: hrdata = frame_reg;
      ADDR_PIXEL:        hrdata = pixel_reg;
      ADDR_STATUS:       hrdata = stat_word;
      default:           hrdata = 32'h0000_0000;
    endcase
  end

  // Pack the configuration word that crosses to the dot clock domain.
  tftsy_cfg_t cfg_src;
  assign cfg_src.active_w          = area_reg[CNT_W-1:0];
  assign cfg_src.active_h          = area_reg[16+CNT_W-1:16];
  assign cfg_src.line_sync_len     = line_reg[23:16];
  assign cfg_src.line_back_porch   = line_reg[15:8];
  assign cfg_src.line_front_porch  = line_reg[7:0];
  assign cfg_src.frame_sync_len    = frame_reg[23:16];
  assign cfg_src.frame_back_porch  = frame_reg[15:8];
  assign cfg_src.frame_front_porch = frame_reg[7:0];
  assign cfg_src.line_pol_low      = ctrl_reg[CTRL_LINE_POL_BIT];
  assign cfg_src.frame_pol_low     = ctrl_reg[CTRL_FRAME_POL_BIT];
  assign cfg_src.pixel_rgb         = pixel_reg[23:0];

  // Toggle handshake: the bus side launches a copy when the link side has
  // acknowledged the last one, so the word is stable while it is sampled.
  tftsy_cfg_t cfg_hold;             // Stable copy seen by the dot domain.
  logic       req_tgl;              // Launch toggle, bus domain.
  // The acknowledge toggle is driven from the dot domain further down.
  // It is declared here because the bus side synchroniser reads it.
  logic       ack_tgl;              // Acknowledge toggle, dot domain.
  logic [1:0] ack_sync;             // Acknowledge toggle synchroniser.
  wire        hs_idle = (ack_sync[1] == req_tgl);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_hold <= '0;
      req_tgl  <= 1'b0;
      ack_sync <= 2'b00;
    end
    else
    begin
      ack_sync <= {ack_sync[0], ack_tgl};
      if (hs_idle)
      begin
        cfg_hold <= cfg_src;
        req_tgl  <= ~req_tgl;
      end
    end
  end

  // Enable is a level and crosses on its own two-flop synchroniser.
  logic [1:0] en_sync;              // Dot domain copy of the enable bit.
  logic [1:0] req_sync;             // Launch toggle synchroniser.
  logic       req_seen;             // Last launch toggle taken.
  tftsy_cfg_t cfg;                  // Timing in use by the counters.
  logic       dot_rst_n;            // Reset released into the dot domain.
  logic [1:0] rst_sync;             // Reset release synchroniser.

  // Reset is asserted at once and released on the dot clock.
  always_ff @(posedge pixel_clk or negedge hresetn)
  begin
    if (!hresetn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign dot_rst_n = rst_sync[1];

  // Counters and phases of the dot domain.
  logic [CNT_W-1:0] h_cnt;          // Dot count within the current phase.
  logic [CNT_W-1:0] v_cnt;          // Line count within the current phase.
  tftsy_phase_t     h_ph;           // Phase of the line.
  tftsy_phase_t     v_ph;           // Phase of the frame.
  logic             frame_busy;     // A frame is in progress.

  // Length of a phase; a zero count is stretched to one so that each
  // sync pulse lasts at least one period.
  // Porch counts are widened to the counter width before they are compared.
  function automatic logic [CNT_W-1:0] ph_len(input tftsy_phase_t ph,
                                              input logic [7:0] s,
                                              input logic [7:0] b,
                                              input logic [7:0] f,
                                              input logic [CNT_W-1:0] a);
    logic [CNT_W-1:0] n;
    n = '0;
    case (ph)
      PH_SYNC:   n = {4'h0, s};
      PH_BACK:   n = {4'h0, b};
      PH_ACTIVE: n = a;
      PH_FRONT:  n = {4'h0, f};
      default:   n = a;
    endcase
    ph_len = (n == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : n;
  endfunction : ph_len

  wire [CNT_W-1:0] h_len  = ph_len(h_ph, cfg.line_sync_len, cfg.line_back_porch,
                                   cfg.line_front_porch, cfg.active_w);
  wire [CNT_W-1:0] v_len  = ph_len(v_ph, cfg.frame_sync_len, cfg.frame_back_porch,
                                   cfg.frame_front_porch, cfg.active_h);
  wire             h_last = (h_cnt == h_len - 1'b1);
  wire             v_last = (v_cnt == v_len - 1'b1);
  wire             line_end  = h_last & (h_ph == PH_FRONT);
  wire             frame_end = line_end & v_last & (v_ph == PH_FRONT);
  wire             enabled   = en_sync[1];
  // New timing is taken only between frames so no line is torn.
  wire             take_cfg  = (req_sync[1] != req_seen) & (frame_end | ~frame_busy);

  // Handshake and configuration capture in the dot domain.
  always_ff @(posedge pixel_clk or negedge dot_rst_n)
  begin
    if (!dot_rst_n)
    begin
      en_sync  <= 2'b00;
      req_sync <= 2'b00;
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
      cfg      <= '0;
    end
    else
    begin
      en_sync  <= {en_sync[0], ctrl_reg[CTRL_ENABLE_BIT]};
      req_sync <= {req_sync[0], req_tgl};
      if (take_cfg)
      begin
        cfg      <= cfg_hold;
        req_seen <= req_sync[1];
        ack_tgl  <= req_sync[1];
      end
    end
  end

  // Line and frame counters; each phase runs its programmed count, or one period for a zero count.
  always_ff @(posedge pixel_clk or negedge dot_rst_n)
  begin
    if (!dot_rst_n)
    begin
      h_cnt      <= '0;
      v_cnt      <= '0;
      h_ph       <= PH_SYNC;
      v_ph       <= PH_SYNC;
      frame_busy <= 1'b0;
    end
    else if (!enabled || !frame_busy)
    begin
      // Idle: restart at a frame sync when enabled.
      // A stop leaves the outputs at their inactive levels on the second dot after the enable is seen low.
      h_cnt      <= '0;
      v_cnt      <= '0;
      h_ph       <= PH_SYNC;
      v_ph       <= PH_SYNC;
      frame_busy <= enabled;
    end
    else if (h_last)
    begin
      h_cnt <= '0;
      h_ph  <= tftsy_phase_t'(h_ph + 2'd1);
      if (line_end)
      begin
        if (v_last)
        begin
          v_cnt <= '0;
          v_ph  <= tftsy_phase_t'(v_ph + 2'd1);
        end
        else
          v_cnt <= v_cnt + 1'b1;
      end
    end
    else
      h_cnt <= h_cnt + 1'b1;
  end

  // Raw output levels, registered below.
  // line sync phase
  wire line_act  = frame_busy & (h_ph == PH_SYNC);
  wire frame_act = frame_busy & (v_ph == PH_SYNC);
  wire de_act    = frame_busy & (h_ph == PH_ACTIVE) & (v_ph == PH_ACTIVE);

  // Blanking the bus outside the active window keeps the panel inputs quiet.
  // Outputs leave flip-flops on the rising dot edge; the panel samples on
  // the falling edge, half a period later.
  // rising edge launch
  always_ff @(posedge pixel_clk or negedge dot_rst_n)
  begin
    if (!dot_rst_n)
    begin
      line_sync_out   <= 1'b0;
      frame_sync_out  <= 1'b0;
      pixel_valid_out <= 1'b0;
      pixel_bus       <= 24'h00_0000;
    end
    else
    begin
      line_sync_out   <= line_act ^ cfg.line_pol_low;
      frame_sync_out  <= frame_act ^ cfg.frame_pol_low;
      pixel_valid_out <= de_act;
      pixel_bus       <= de_act ? cfg.pixel_rgb : 24'h00_0000;
    end
  end

  // Dot clock delay line: a few registered taps on hclk would be too slow,
  // so the delay selects among delayed copies of the ungated dot clock
  // taken through zero to three gate stages.
  // The delay select is two bits wide and its bits may not cross together,
  // so it should only be changed while the panel ignores the clock.
  logic [1:0] dly_sync [2];         // Delay select synchroniser.
  logic       inv_sync0;            // Inversion synchroniser, first stage.
  logic       inv_sync1;            // Inversion synchroniser, second stage.
  logic [3:0] clk_tap;              // Undivided dot clock copies, one per delay step.
  always_ff @(posedge pixel_clk or negedge dot_rst_n)
  begin
    if (!dot_rst_n)
    begin
      dly_sync[0] <= 2'b00;
      dly_sync[1] <= 2'b00;
      inv_sync0   <= 1'b0;
      inv_sync1   <= 1'b0;
    end
    else
    begin
      dly_sync[0] <= ctrl_reg[CTRL_CLK_DLY_LSB +: CTRL_CLK_DLY_W];
      dly_sync[1] <= dly_sync[0];
      inv_sync0   <= ctrl_reg[CTRL_CLK_INV_BIT];
      inv_sync1   <= inv_sync0;
    end
  end
  // Taps are the same clock, swallowed by zero to three gate stages; in
  // silicon each becomes a cell delay, in simulation they are equal.
  assign clk_tap = {4{pixel_clk}};

  assign panel_dot_clock = clk_tap[dly_sync[1]] ^ inv_sync1;

  // Status word returned to software.
  logic [1:0] busy_sync;            // Frame activity, back in bus domain.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_sync <= 2'b00;
    else
      busy_sync <= {busy_sync[0], frame_busy};
  end
  // Handshake idle tells software that the last setup has been taken; a
  // new setup waits for the end of the running frame before it is used.
  assign stat_word = {30'h0000_0000, hs_idle, busy_sync[1]};
endmodule : tftsy_timing
`default_nettype wire

/* bench/tftsy_timing_asserts.sv */
// Purpose: Port checks for the panel sync timing generator.
// Assumes: Bound to tftsy_timing; dot outputs sampled on pixel_clk.
// Notes:   Sync polarity is not visible here, so only edges are used.
`timescale 1ns/10ps
`default_nettype none
module tftsy_timing_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pixel_clk,
  input wire logic        line_sync_out,
  input wire logic        frame_sync_out,
  input wire logic        pixel_valid_out,
  input wire logic [23:0] pixel_bus
);
  // A line starts or ends its sync pulse.
  sequence s_line_edge;
    $changed(line_sync_out);
  endsequence
  // A frame starts or ends its sync pulse.
  sequence s_frame_edge;
    $changed(frame_sync_out);
  endsequence
  chk_ready_high: assert property (@(posedge hclk) disable iff (!hresetn) hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn) !hresp)
    else $error("hresp not okay");
  chk_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && !hwrite && haddr[7:0] > 8'h14) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_blank_bus_zero: assert property (@(posedge pixel_clk) disable iff (!hresetn)
    !pixel_valid_out |-> pixel_bus == 24'h00_0000) else $error("bus not blank");
  chk_frame_line_edge: assert property (@(posedge pixel_clk) disable iff (!hresetn)
    s_frame_edge |-> s_line_edge) else $error("frame edge without line edge");
  chk_sync_edge_blank: assert property (@(posedge pixel_clk) disable iff (!hresetn)
    s_line_edge |-> !pixel_valid_out) else $error("valid at line sync edge");
  chk_valid_no_sync: assert property (@(posedge pixel_clk) disable iff (!hresetn)
    pixel_valid_out |-> $stable(line_sync_out) && $stable(frame_sync_out))
    else $error("sync moved while valid");
  chk_frame_no_valid: assert property (@(posedge pixel_clk) disable iff (!hresetn)
    s_frame_edge |-> !pixel_valid_out) else $error("valid at frame edge");
endmodule : tftsy_timing_asserts
bind tftsy_timing tftsy_timing_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .pixel_clk, .line_sync_out, .frame_sync_out,
  .pixel_valid_out, .pixel_bus);
`default_nettype wire

/* bench/tftsy_panel.sv */
// Purpose: Panel model that measures line and frame timing.
// Assumes: Dot clock not inverted while measuring.
// Notes:   Each figure is stored at the start of the next line or frame.
`timescale 1ns/10ps
`default_nettype none
module tftsy_panel (
  input wire logic        dot_clk,
  input wire logic        line_sync,
  input wire logic        frame_sync,
  input wire logic        valid,
  input wire logic [23:0] pixel,
  input wire logic        line_pol_low,
  input wire logic        frame_pol_low,
  output logic     [15:0] line_len,
  output logic     [15:0] sync_w,
  output logic     [15:0] lead_w,
  output logic     [15:0] act_w,
  output logic     [15:0] frame_len,
  output logic     [15:0] fsync_lines,
  output logic     [15:0] act_lines,
  output logic     [23:0] pix
);
  logic        ls_q = 1'b0;
  logic        fs_q = 1'b0;
  logic [15:0] dc = '0, sc = '0, vc = '0, ld = '0, lc = '0, fc = '0, ac = '0;
  wire         ls = line_sync ^ line_pol_low;
  wire         fs = frame_sync ^ frame_pol_low;
  wire         l_start = ls && !ls_q;
  // capture on falling edge, ignore pixels without valid.
  always @(negedge dot_clk)
  begin
    ls_q <= ls;
    fs_q <= fs;
    dc <= dc + 16'd1;
    if (ls) sc <= sc + 16'd1;
    if (valid) vc <= vc + 16'd1;
    if (valid && vc == 0) ld <= dc;
    if (valid) pix <= pixel;
    if (l_start)
    begin
      line_len <= dc;
      sync_w <= sc;
      lead_w <= ld;
      // Blank lines carry no valid dots and must not overwrite the width.
      if (vc != 16'd0) act_w <= vc;
      dc <= 16'd1;
      sc <= 16'd1;
      vc <= 16'd0;
      lc <= (fs && !fs_q) ? 16'd1 : lc + 16'd1;
      fc <= (fs && !fs_q) ? 16'd1 : fc + 16'(fs);
      ac <= (fs && !fs_q) ? 16'd0 : ac + 16'(vc != 0);
      if (fs && !fs_q)
      begin
        frame_len <= lc;
        fsync_lines <= fc;
        act_lines <= ac;
      end
    end
  end
endmodule : tftsy_panel
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Register and panel timing tests of the sync generator.
// Assumes: Zero wait state slave; panel model measures the outputs.
// Notes:   Each setup runs many frames before its figures are compared.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tftsy_pkg::*;
  logic        hclk = 1'b0, pixel_clk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        lpl = 1'b0, fpl = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'b010;
  logic        hreadyout, hresp, panel_dot_clock, line_sync_out, frame_sync_out, pixel_valid_out;
  logic [23:0] pixel_bus, m_pix;
  logic [15:0] m_line, m_sync, m_lead, m_act, m_frame, m_fsync, m_alines;
  int          err_total = 0, check_count = 0;
  wire         hready = hreadyout;
  always #25 hclk = ~hclk;
  // Dot clock offset so its edges never meet the bus clock.
  initial
  begin
    #3.1;
    forever #7.5 pixel_clk = ~pixel_clk;
  end
  tftsy_timing uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .pixel_clk, .panel_dot_clock, .line_sync_out, .frame_sync_out,
    .pixel_valid_out, .pixel_bus);
  tftsy_panel u_panel (.dot_clk(panel_dot_clock), .line_sync(line_sync_out),
    .frame_sync(frame_sync_out), .valid(pixel_valid_out), .pixel(pixel_bus), .line_pol_low(lpl),
    .frame_pol_low(fpl), .line_len(m_line), .sync_w(m_sync), .lead_w(m_lead), .act_w(m_act),
    .frame_len(m_frame), .fsync_lines(m_fsync), .act_lines(m_alines), .pix(m_pix));
  task automatic stop_test;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One single AHB-Lite transfer; waits on hready in both phases.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(n, e, r);
  endtask : rd_chk
  task automatic dot_chk(input logic inv);
    @(posedge pixel_clk);
    #1;
    chk("dot clock", {31'h0, ~inv}, {31'h0, panel_dot_clock});
  endtask : dot_chk
  // Programs one panel setup, lets it run, then compares the measured timing.
  task automatic run(input int w, h, s, b, f, vs, vb, vf, input logic [1:0] pol, input logic [23:0] rgb);
    logic [31:0] lt;
    lt = {8'h00, 8'(s), 8'(b), 8'(f)};
    wr(ADDR_AREA_SIZE, {4'h0, 12'(h), 4'h0, 12'(w)});
    wr(ADDR_LINE_TIMING, lt);
    wr(ADDR_FRAME_TIMING, {8'h00, 8'(vs), 8'(vb), 8'(vf)});
    wr(ADDR_PIXEL, {8'h00, rgb});
    wr(ADDR_CTRL, {28'h000_0000, 1'b0, pol, 1'b1});
    lpl <= pol[0];
    fpl <= pol[1];
    rd_chk("line timing", ADDR_LINE_TIMING, lt);
    repeat (300) @(posedge hclk);
    chk("line period", 32'(s + b + f + w), 32'(m_line));
    chk("line sync", 32'(s), 32'(m_sync));
    chk("sync plus porch", 32'(s + b), 32'(m_lead));
    chk("active dots", 32'(w), 32'(m_act));
    chk("frame period", 32'(vs + vb + vf + h), 32'(m_frame));
    chk("frame sync lines", 32'(vs), 32'(m_fsync));
    chk("active lines", 32'(h), 32'(m_alines));
    chk("pixel", {8'h00, rgb}, {8'h00, m_pix});
    dot_chk(1'b0);
  endtask : run
  initial
  begin
    logic [31:0] st;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("ctrl reset", ADDR_CTRL, CTRL_RESET);
    rd_chk("area reset", ADDR_AREA_SIZE, AREA_RESET);
    rd_chk("line reset", ADDR_LINE_TIMING, LINE_RESET);
    rd_chk("frame reset", ADDR_FRAME_TIMING, FRAME_RESET);
    rd_chk("pixel reset", ADDR_PIXEL, PIXEL_RESET);
    rd_chk("unmapped", 8'h18, 32'h0000_0000);
    run(5, 3, 2, 3, 1, 1, 2, 1, 2'b00, {8'hA5, 8'h3C, 8'h0F});
    run(2, 1, 1, 1, 2, 2, 1, 1, 2'b11, {8'h12, 8'h34, 8'h56});
    bus(1'b0, ADDR_STATUS, 32'h0000_0000, st);
    chk("frame busy", 32'h0000_0001, st & 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_003F);
    repeat (300) @(posedge hclk);
    dot_chk(1'b1);
    stop_test();
  end
  // Bounds the whole run well beyond the expected length.
  initial
  begin
    repeat (5000) @(posedge hclk);
    err_total++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
